/* File: rtl/sbs_burst_ctr.sv */
// sbs_burst_ctr: 2-bit burst counter producing the low address bits
// assumes load and step are computed by the parent in the same cycle
`timescale 1ns/100ps
`default_nettype none
module sbs_burst_ctr
  import sbs_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic load,
  input wire logic step,
  input wire logic linear,
  input wire logic [SEED_W-1:0] seed,
  output logic [SEED_W-1:0] low_bits
);
  logic [SEED_W-1:0] seed_q, seed_d;
  logic [SEED_W-1:0] cnt_q, cnt_d;
  logic [SEED_W-1:0] low_q, low_d;

  always_comb begin
    seed_d = seed_q;
    cnt_d = cnt_q;
    if (load) begin
      seed_d = seed;
      cnt_d = SEED_RST;
    end else if (step) begin
      cnt_d = cnt_q + SEED_ONE;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      seed_q <= SEED_RST;
      cnt_q <= SEED_RST;
      low_q <= SEED_RST;
    end else begin
      seed_q <= seed_d;
      cnt_q <= cnt_d;
      low_q <= low_d;
    end
  end

  // linear adds the step count, interleaved xors it into the seed;
  // worked out from the next values so the low address leaves a flop
  always_comb begin
    if (linear) begin
      low_d = seed_d + cnt_d;
    end else begin
      low_d = seed_d ^ cnt_d;
    end
  end

  assign low_bits = low_q;
endmodule
`default_nettype wire

/* File: rtl/sbs_input_ctrl.sv */
// sbs_input_ctrl: synchronous address, select and write qualification
// assumes inputs synchronous to clk; burst_order strap static in operation
`timescale 1ns/100ps
`default_nettype none
module sbs_input_ctrl
  import sbs_pkg::*;
#(
  parameter bit BGA_VARIANT = 1'b0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire sbs_req_t req,
  input wire logic burst_order,
  output logic [ADDR_W-1:0] mem_addr,
  output logic selected,
  output logic addr_loaded,
  output logic [LANES-1:0] lane_wr
);
  sbs_state_t state_q, state_d;
  logic [ADDR_W-1:SEED_W] upper_q, upper_d;
  logic sel_q, sel_d;
  logic load_q, load_d;
  logic [LANES-1:0] wr_q, wr_d;
  logic order_q, order_d;
  logic chip_on, proc_load, ctrl_load, load, step;
  logic [SEED_W-1:0] low_bits;

  function automatic logic enables_active(input sbs_req_t r, input bit bga);
    return !r.select_primary_n && r.select_depth_hi
      && (bga || !r.select_depth_lo_n);
  endfunction

  always_comb begin
    chip_on = enables_active(req, BGA_VARIANT);
    proc_load = !req.proc_addr_strobe_n && !req.select_primary_n;
    // processor strobe takes priority when both are low
    ctrl_load = !req.ctrl_addr_strobe_n && req.proc_addr_strobe_n;
    load = (proc_load || ctrl_load) && chip_on;
    step = !load && (state_q == SBS_BURST) && !req.burst_advance_n;
  end

  sbs_burst_ctr u_ctr (
    .clk(clk),
    .resetn(resetn),
    .load(load),
    .step(step),
    .linear(!order_q),
    .seed(req.addr[SEED_W-1:0]),
    .low_bits(low_bits)
  );

  always_comb begin
    state_d = state_q;
    upper_d = upper_q;
    sel_d = sel_q;
    load_d = load;
    wr_d = LANES_NONE;
    order_d = burst_order;
    case (state_q)
      SBS_IDLE, SBS_BURST: begin
        if (load) begin
          upper_d = req.addr[ADDR_W-1:SEED_W];
          sel_d = 1'b1;
          state_d = SBS_BURST;
        end
      end
      default: state_d = SBS_IDLE;
    endcase
    if (!req.all_bytes_wr_n) begin
      wr_d = LANES_ALL;
    end else if (!req.byte_wr_en_n) begin
      wr_d = ~req.byte_lane_sel_n;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= SBS_IDLE;
      upper_q <= ADDR_RST[ADDR_W-1:SEED_W];
      sel_q <= 1'b0;
      load_q <= 1'b0;
      wr_q <= LANES_NONE;
      order_q <= 1'b1;
    end else begin
      state_q <= state_d;
      upper_q <= upper_d;
      sel_q <= sel_d;
      load_q <= load_d;
      wr_q <= wr_d;
      order_q <= order_d;
    end
  end

  // low bits come from counter flops; the concatenation is a pure wiring of flops
  assign mem_addr = {upper_q, low_bits};
  assign selected = sel_q;
  assign addr_loaded = load_q;
  assign lane_wr = wr_q;

  AST_LOAD_UPPER: assert property (@(posedge clk) disable iff (!resetn)
    load |=> upper_q == $past(req.addr[ADDR_W-1:SEED_W]))
    else $error("upper address not captured on load");
  AST_NO_LOAD_HOLD: assert property (@(posedge clk) disable iff (!resetn)
    !load |=> $stable(upper_q))
    else $error("upper address moved without load");
  AST_SEED: assert property (@(posedge clk) disable iff (!resetn)
    load |=> low_bits == $past(req.addr[SEED_W-1:0]))
    else $error("counter not seeded from low bits");
  AST_PROC_IGNORED: assert property (@(posedge clk) disable iff (!resetn)
    req.select_primary_n |-> !load)
    else $error("load with primary enable high");
  AST_SELECT: assert property (@(posedge clk) disable iff (!resetn)
    load |-> !req.select_primary_n && req.select_depth_hi)
    else $error("load while not selected");
  AST_GLOBAL: assert property (@(posedge clk) disable iff (!resetn)
    !req.all_bytes_wr_n |=> lane_wr == LANES_ALL)
    else $error("global write missed lanes");
  AST_BYTE: assert property (@(posedge clk) disable iff (!resetn)
    req.all_bytes_wr_n && req.byte_wr_en_n |=> lane_wr == LANES_NONE)
    else $error("lane written without byte enable");
  AST_LANES: assert property (@(posedge clk) disable iff (!resetn)
    req.all_bytes_wr_n && !req.byte_wr_en_n |=> lane_wr == ~$past(req.byte_lane_sel_n))
    else $error("lane write mismatch");
  sequence s_adv;
    !load && state_q == SBS_BURST && !req.burst_advance_n && !order_q;
  endsequence
  AST_STEP: assert property (@(posedge clk) disable iff (!resetn)
    s_adv ##1 !order_q |-> low_bits == $past(low_bits) + SEED_ONE)
    else $error("linear burst did not advance");
  AST_PRIO: assert property (@(posedge clk) disable iff (!resetn)
    !req.proc_addr_strobe_n && req.select_primary_n |-> !load)
    else $error("controller strobe acted with processor strobe low");
  AST_SEL_HOLD: assert property (@(posedge clk) disable iff (!resetn)
    !load |=> $stable(selected))
    else $error("select changed without load");

  // enabled strobe requests, chip enables as sampled at the load edge
  sequence s_proc_req;
    !req.proc_addr_strobe_n && !req.select_primary_n && req.select_depth_hi
      && (BGA_VARIANT || !req.select_depth_lo_n);
  endsequence

  sequence s_ctrl_req;
    req.proc_addr_strobe_n && !req.ctrl_addr_strobe_n && !req.select_primary_n
      && req.select_depth_hi && (BGA_VARIANT || !req.select_depth_lo_n);
  endsequence

  sequence s_adv_il;
    !load && state_q == SBS_BURST && !req.burst_advance_n && order_q;
  endsequence

  AST_PROC_TAKE: assert property (@(posedge clk) disable iff (!resetn)
    s_proc_req |-> load)
    else $error("enabled processor strobe not taken");

  AST_CTRL_TAKE: assert property (@(posedge clk) disable iff (!resetn)
    s_ctrl_req |-> load)
    else $error("enabled controller strobe not taken");

  AST_PROC_ADDR: assert property (@(posedge clk) disable iff (!resetn)
    s_proc_req |=> mem_addr == $past(req.addr))
    else $error("processor load address not presented");

  AST_CTRL_ADDR: assert property (@(posedge clk) disable iff (!resetn)
    s_ctrl_req |=> mem_addr == $past(req.addr))
    else $error("controller load address not presented");

  AST_NO_STROBE: assert property (@(posedge clk) disable iff (!resetn)
    req.proc_addr_strobe_n && req.ctrl_addr_strobe_n |-> !load)
    else $error("load without any strobe");

  AST_DEPTH_HI: assert property (@(posedge clk) disable iff (!resetn)
    !req.select_depth_hi |-> !load)
    else $error("load with high depth select inactive");

  AST_DEPTH_LO: assert property (@(posedge clk) disable iff (!resetn)
    !BGA_VARIANT && req.select_depth_lo_n |-> !load)
    else $error("load with low depth select inactive");

  AST_PULSE_ON: assert property (@(posedge clk) disable iff (!resetn)
    load |=> addr_loaded)
    else $error("load pulse missing");

  AST_PULSE_OFF: assert property (@(posedge clk) disable iff (!resetn)
    !load |=> !addr_loaded)
    else $error("load pulse without load");

  AST_SEL_SET: assert property (@(posedge clk) disable iff (!resetn)
    load |=> selected)
    else $error("select not set on load");

  AST_ADV_HOLD: assert property (@(posedge clk) disable iff (!resetn)
    !load && req.burst_advance_n |=> $stable(low_bits))
    else $error("burst counter moved without advance");

  AST_IDLE_HOLD: assert property (@(posedge clk) disable iff (!resetn)
    state_q == SBS_IDLE && !load |=> $stable(low_bits))
    else $error("burst counter moved outside a burst");

  AST_IL_STEP: assert property (@(posedge clk) disable iff (!resetn)
    s_adv_il |=> low_bits != $past(low_bits))
    else $error("interleaved burst did not advance");

  AST_ORDER: assert property (@(posedge clk) disable iff (!resetn)
    1'b1 |=> order_q == $past(burst_order))
    else $error("burst order strap not registered");

  AST_WR_CAUSE: assert property (@(posedge clk) disable iff (!resetn)
    lane_wr != LANES_NONE |-> !$past(req.all_bytes_wr_n) || !$past(req.byte_wr_en_n))
    else $error("lane write without a write input");

  AST_UPPER_OUT: assert property (@(posedge clk) disable iff (!resetn)
    !load |=> $stable(mem_addr[ADDR_W-1:SEED_W]))
    else $error("presented upper address moved without load");
endmodule
`default_nettype wire

/* File: rtl/sbs_pkg.sv */
// sbs_pkg: shared types and constants for the burst sram input control block
// assumes a single clock domain and active-low async reset
package sbs_pkg;
  localparam int ADDR_W = 20;
  localparam int LANES = 4;
  localparam int SEED_W = 2;
  localparam logic [ADDR_W-1:0] ADDR_RST = 20'h00000;
  localparam logic [SEED_W-1:0] SEED_RST = 2'h0;
  localparam logic [SEED_W-1:0] SEED_ONE = 2'h1;
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;
  localparam logic [LANES-1:0] LANES_ALL = 4'hf;

  // bus-side inputs sampled at each rising edge
  typedef struct packed {
    logic proc_addr_strobe_n;
    logic ctrl_addr_strobe_n;
    logic burst_advance_n;
    logic select_primary_n;
    logic select_depth_hi;
    logic select_depth_lo_n;
    logic byte_wr_en_n;
    logic all_bytes_wr_n;
    logic [LANES-1:0] byte_lane_sel_n;
    logic [ADDR_W-1:0] addr;
  } sbs_req_t;

  typedef enum logic [1:0] {
    SBS_IDLE = 2'b00,
    SBS_BURST = 2'b01
  } sbs_state_t;
endpackage

/* File: tb/sbs_ctl_model.sv */
// sbs_ctl_model: controller side driving strobes, selects and writes
// assumes a free-running clock; seeds $urandom once itself, drives on the falling edge
`timescale 1ns/100ps
`default_nettype none
module sbs_ctl_model
  import sbs_pkg::*;
(
  input wire logic clk,
  input wire logic [1:0] mode,
  output var sbs_req_t req
);
  sbs_req_t r;
  always begin
    void'($urandom(87));
    req = '1;
    forever begin
      @(negedge clk);
      r = sbs_req_t'($urandom);
      if ($urandom_range(3) != 0 || mode != 2'h0) begin
        r.select_primary_n = 1'b0;
        r.select_depth_hi = 1'b1;
        r.select_depth_lo_n = 1'b0;
      end
      r.proc_addr_strobe_n = ($urandom_range(3) != 0);
      r.ctrl_addr_strobe_n = ($urandom_range(3) != 0);
      // both strobes at once, refused strobe, or a pure advance run
      if (mode == 2'h1) r.proc_addr_strobe_n = 1'b0;
      if (mode == 2'h1) r.ctrl_addr_strobe_n = 1'b0;
      if (mode == 2'h2) r.select_primary_n = 1'b1;
      if (mode == 2'h2) r.proc_addr_strobe_n = 1'b0;
      if (mode == 2'h3) r = '{burst_advance_n: 1'b0, addr: r.addr, default: 1'b1};
      req <= r;
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// tb_top: random and corner stimulus against both chip-enable variants
// assumes the partner model owns the request bus
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import sbs_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic burst_order = 1'b0;
  logic [1:0] mode = 2'h0;
  sbs_req_t req;
  logic [ADDR_W-1:0] ma [2];
  logic sel [2];
  logic ld [2];
  logic [LANES-1:0] wr [2];
  logic [ADDR_W-1:0] e_up [2];
  logic [1:0] e_cnt [2];
  logic e_ld [2];
  logic e_sel [2];
  logic [LANES-1:0] e_wr [2];
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #10 clk = ~clk;
  sbs_ctl_model partner (.clk(clk), .mode(mode), .req(req));
  sbs_input_ctrl #(.BGA_VARIANT(1'b0)) dut (.clk(clk), .resetn(resetn), .req(req),
    .burst_order(burst_order), .mem_addr(ma[0]), .selected(sel[0]), .addr_loaded(ld[0]),
    .lane_wr(wr[0]));
  sbs_input_ctrl #(.BGA_VARIANT(1'b1)) dut_bga (.clk(clk), .resetn(resetn), .req(req),
    .burst_order(burst_order), .mem_addr(ma[1]), .selected(sel[1]), .addr_loaded(ld[1]),
    .lane_wr(wr[1]));
  function automatic logic [1:0] low_of(input logic [1:0] b, input logic [1:0] c);
    return burst_order ? (b ^ c) : (b + c);
  endfunction
  task automatic results();
    if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  always @(posedge clk or negedge resetn) begin : ref_model
    logic load;
    for (int i = 0; i < 2; i++) begin
      load = !req.select_primary_n && req.select_depth_hi && (!req.select_depth_lo_n || i == 1)
        && (!req.proc_addr_strobe_n || !req.ctrl_addr_strobe_n);
      if (!resetn) load = 1'b0;
      if (load) e_up[i] <= req.addr;
      e_cnt[i] <= load || !resetn ? 2'h0 : e_cnt[i] + {1'b0, e_sel[i] && !req.burst_advance_n};
      if (!resetn) e_up[i] <= ADDR_RST;
      e_ld[i] <= load;
      e_sel[i] <= resetn && (e_sel[i] || load);
      e_wr[i] <= !resetn ? LANES_NONE : !req.all_bytes_wr_n ? LANES_ALL
        : req.byte_wr_en_n ? LANES_NONE : ~req.byte_lane_sel_n;
    end
  end
  always @(negedge clk) if (resetn) for (int i = 0; i < 2; i++) begin
    chk(ma[i], {e_up[i][ADDR_W-1:2], low_of(e_up[i][1:0], e_cnt[i])});
    chk(ld[i], e_ld[i]);
    chk(sel[i], e_sel[i]);
    chk(wr[i], e_wr[i]);
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    for (int ph = 0; ph < 2; ph++) begin
      burst_order = ph[0];
      repeat (6) @(posedge clk);
      @(negedge clk) resetn = 1'b1;
      repeat (4) begin
        repeat (150) @(negedge clk);
        mode <= 2'h1;
        repeat (3) @(negedge clk);
        mode <= 2'h2;
        repeat (3) @(negedge clk);
        mode <= 2'h3;
        repeat (6) @(negedge clk);
        mode <= 2'h0;
      end
      @(negedge clk) resetn = 1'b0;
    end
    results();
  end
endmodule
`default_nettype wire
